// [rtl/lhwp_map.svh]
// Constants for the display host write port.
// Assumes inclusion by the top module only.
`ifndef LHWP_MAP_SVH
`define LHWP_MAP_SVH
`define LHWP_DEV_ADDR      7'h3E
`define LHWP_RST_BYTE      8'h00
`define LHWP_RST_AC        7'h00
`define LHWP_BUSY_NS       40
`define LHWP_BUSY_CYC      ((`LHWP_BUSY_NS + 4) / 5)
`define LHWP_FIFO_DEPTH    16
`define LHWP_CO_BIT        7
`define LHWP_RS_BIT        6
`define LHWP_DL_BIT        4
`define LHWP_FSET_BIT      5
`define LHWP_ADDR_BIT      7
`endif

// [rtl/lhwp_pkg.sv]
// Types shared by the display host write port.
// Assumes no other package.
package lhwp_pkg;
  typedef struct packed {
    logic       register_select;
    logic [7:0] data;
  } lhwp_word_t;

  typedef struct packed {
    logic       busy_flag;
    logic [6:0] address_counter;
  } lhwp_stat_t;
endpackage

// [rtl/lhwp_fifo.sv]
// Word FIFO between link and core domains (gray pointers).
// Assumes independent clocks, synchronous active high resets.
`timescale 1ns/1ps
module lhwp_fifo #(
  parameter int W = 9,
  parameter int D = 16
) (
  input  wire logic         wclk,
  input  wire logic         wrst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  input  wire logic         rclk,
  input  wire logic         rrst,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int A = $clog2(D);
  logic [W-1:0] mem [D];
  logic [A:0]   wbin_r;
  logic [A:0]   wgray_r;
  logic [A:0]   rbin_r;
  logic [A:0]   rgray_r;
  logic [A:0]   rg_s1_r;
  logic [A:0]   rg_s2_r;
  logic [A:0]   wg_s1_r;
  logic [A:0]   wg_s2_r;
  logic [A:0]   wbin_nxt;
  logic [A:0]   rbin_nxt;
  logic         wfire;
  logic         rfire;

  assign in_ready  = (wgray_r != {~rg_s2_r[A:A-1], rg_s2_r[A-2:0]});
  assign out_valid = (rgray_r != wg_s2_r);
  assign wfire     = in_valid && in_ready;
  assign rfire     = out_valid && out_ready;
  assign wbin_nxt  = wbin_r + {{A{1'b0}}, 1'b1};
  assign rbin_nxt  = rbin_r + {{A{1'b0}}, 1'b1};
  assign out_data  = mem[rbin_r[A-1:0]];

  always_ff @(posedge wclk)
  begin
    if (wfire)
      mem[wbin_r[A-1:0]] <= in_data;
  end

  always_ff @(posedge wclk)
  begin
    if (wrst)
    begin
      wbin_r  <= '0;
      wgray_r <= '0;
      rg_s1_r <= '0;
      rg_s2_r <= '0;
    end
    else
    begin
      rg_s1_r <= rgray_r;
      rg_s2_r <= rg_s1_r;
      if (wfire)
      begin
        wbin_r  <= wbin_nxt;
        wgray_r <= wbin_nxt ^ (wbin_nxt >> 1);
      end
    end
  end

  always_ff @(posedge rclk)
  begin
    if (rrst)
    begin
      rbin_r  <= '0;
      rgray_r <= '0;
      wg_s1_r <= '0;
      wg_s2_r <= '0;
    end
    else
    begin
      wg_s1_r <= wgray_r;
      wg_s2_r <= wg_s1_r;
      if (rfire)
      begin
        rbin_r  <= rbin_nxt;
        rgray_r <= rbin_nxt ^ (rbin_nxt >> 1);
      end
    end
  end
endmodule

// [rtl/lhwp_top.sv]
// Host write port of a character display controller: two-wire slave
// on the serial clock, parallel 4/8-bit host port on mclk, RAM write-out.
// Assumes serial clock runs only while a master drives it.
// Operation
// - Answer only fixed address 0111110.
// - Accept instruction and RAM data writes.
// - Drive only acknowledge on data line.
// - Serial clock input only, samples data.
// - Reset while reset pin low.
// - Parallel width from bus width select.
// - Separate instruction and data holding registers.
// - Data register auto-written into RAM.
// - Data read reloads from next address.
// - Instruction register is never readable.
// - Select and direction decode, parallel mode.
// - Control byte then data; continuation flag.
// - Acknowledge every control byte, and data bytes only while the buffer has room.
// - Busy rejects a parallel instruction; a buffered serial one waits.
`timescale 1ns/1ps
`include "lhwp_map.svh"
module lhwp_top (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       rst_pin_n,
  input  wire logic       scl,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       par_mode,
  input  wire logic       par_strobe,
  input  wire logic       register_select,
  input  wire logic       par_read,
  input  wire logic [7:0] par_din,
  output logic [7:0]      par_dout,
  output logic            busy_flag,
  output logic            bus_width_select,
  output logic [7:0]      instruction_holding_reg,
  output logic [7:0]      data_holding_reg,
  output logic [6:0]      address_counter,
  output logic            ram_we,
  output logic [6:0]      ram_addr,
  output logic [7:0]      ram_wdata,
  input  wire logic [7:0] ram_rdata,
  output logic            instr_valid
);
  typedef enum logic [4:0] {
    LHWP_IDLE = 5'b00001,
    LHWP_ADDR = 5'b00010,
    LHWP_CTRL = 5'b00100,
    LHWP_DATA = 5'b01000,
    LHWP_SKIP = 5'b10000
  } lhwp_st_t;

  // reset pin low holds both domains
  // Three-flop filter: a pin glitch shorter than one mclk is ignored
  logic [2:0] rp_sy_r;
  logic       rst_core_r;
  logic [1:0] lrst_r;
  logic       lrst;
  always_ff @(posedge mclk)
  begin
    rp_sy_r <= {rp_sy_r[1:0], rst_pin_n};
    if (rst)
      rst_core_r <= 1'b1;
    else if (rp_sy_r[2] == rp_sy_r[1])
      rst_core_r <= ~rp_sy_r[1];
  end

  // Link reset reaches scl logic only through two flops on scl
  always_ff @(posedge scl)
  begin
    lrst_r <= {lrst_r[0], rst_core_r};
  end
  assign lrst = lrst_r[1];

  // Start/stop edges seen on data line; sampled under scl
  // Power-up value: no data edge is guaranteed while the link
  // reset is held, so these toggles cannot take a reset there
  logic start_tg_r = 1'b0;
  logic stop_tg_r  = 1'b0;
  logic st_seen_r;
  logic sp_seen_r;
  always_ff @(negedge sda_in)
  begin
    if (scl)
      start_tg_r <= ~start_tg_r;
  end

  always_ff @(posedge sda_in)
  begin
    if (scl)
      stop_tg_r <= ~stop_tg_r;
  end

  lhwp_st_t   st_r;
  logic [3:0] bit_r;
  logic [7:0] sh_r;
  logic       rs_r;
  logic       co_r;
  logic       ack_r;
  logic       fifo_ready;
  logic       push_r;
  logic [8:0] push_d_r;
  logic       start_ev;
  logic       stop_ev;
  logic [7:0] byte_v;
  assign start_ev = (start_tg_r != st_seen_r);
  assign stop_ev  = (stop_tg_r != sp_seen_r);
  assign byte_v   = {sh_r[6:0], sda_in};

  // serial clock only clocks the link logic
  always_ff @(posedge scl)
  begin
    push_r <= 1'b0;
    if (lrst)
    begin
      st_r      <= LHWP_IDLE;
      bit_r     <= 4'h0;
      sh_r      <= `LHWP_RST_BYTE;
      rs_r      <= 1'b0;
      co_r      <= 1'b1;
      st_seen_r <= start_tg_r;
      sp_seen_r <= stop_tg_r;
    end
    else if (start_ev || stop_ev)
    begin
      st_seen_r <= start_tg_r;
      sp_seen_r <= stop_tg_r;
      st_r      <= stop_ev && !start_ev ? LHWP_IDLE : LHWP_ADDR;
      bit_r     <= 4'h1;
      sh_r      <= {7'h00, sda_in};
      co_r      <= 1'b1;
    end
    else if (st_r != LHWP_IDLE && st_r != LHWP_SKIP)
    begin
      if (bit_r == 4'h8)
        bit_r <= 4'h0;
      else
        bit_r <= bit_r + 4'h1;
      if (bit_r < 4'h8)
        sh_r <= byte_v;
      if (bit_r == 4'h7)
      begin
        unique case (st_r)
          LHWP_ADDR:
          begin
            if (byte_v[7:1] != `LHWP_DEV_ADDR || byte_v[0])
              st_r <= LHWP_SKIP;
          end
          LHWP_CTRL:
          begin
            rs_r <= byte_v[`LHWP_RS_BIT];
            co_r <= byte_v[`LHWP_CO_BIT];
          end
          LHWP_DATA:
          begin
            // both instruction and data words pass
            push_r   <= 1'b1;
            push_d_r <= {rs_r, byte_v};
          end
          default:
            st_r <= LHWP_SKIP;
        endcase
      end
      if (bit_r == 4'h8)
      begin
        if (st_r == LHWP_ADDR || (st_r == LHWP_DATA && co_r))
          st_r <= LHWP_CTRL;
        else if (st_r == LHWP_CTRL)
          st_r <= LHWP_DATA;
      end
    end
  end

  // nothing but acknowledge goes on the line
  // Full buffer refuses the byte: no ack, so the host sees the loss
  logic ack_nxt;
  always_comb
  begin
    ack_nxt = 1'b0;
    if (bit_r == 4'h8 && st_r != LHWP_IDLE && st_r != LHWP_SKIP)
      ack_nxt = !(st_r == LHWP_DATA && !fifo_ready);
  end

  always_ff @(negedge scl)
  begin
    if (lrst)
      ack_r <= 1'b0;
    else
      ack_r <= ack_nxt;
  end
  assign sda_out = 1'b0;
  assign sda_oe  = ack_r;

  // Buffer decouples scl from mclk; it holds up to 16 words
  // while the parallel port owns the core
  lhwp_pkg::lhwp_word_t fifo_w;
  logic                 fifo_v;
  logic                 fifo_take;
  lhwp_fifo #(
    .W (9),
    .D (`LHWP_FIFO_DEPTH)
  ) u_fifo (
    .wclk      (scl),
    .wrst      (lrst),
    .in_valid  (push_r),
    .in_ready  (fifo_ready),
    .in_data   (push_d_r),
    .rclk      (mclk),
    .rrst      (rst_core_r),
    .out_valid (fifo_v),
    .out_ready (fifo_take),
    .out_data  (fifo_w)
  );

  // Parallel strobe edge after the three-stage filter
  logic [2:0] stb_sy_r;
  logic       stb_lvl_r;
  logic       par_ev;
  always_ff @(posedge mclk)
  begin
    stb_sy_r <= {stb_sy_r[1:0], par_strobe};
    if (rst_core_r)
      stb_lvl_r <= 1'b0;
    else if (stb_sy_r[2] == stb_sy_r[1])
      stb_lvl_r <= stb_sy_r[1];
  end

  assign par_ev = par_mode && (stb_sy_r[2] == stb_sy_r[1]) && stb_sy_r[1] && !stb_lvl_r;

  logic [7:0] busy_cnt_r;
  logic       nib_hi_r;
  logic [3:0] nib_r;
  logic       wr_ev;
  logic       wr_rs;
  logic [7:0] wr_d;
  logic       rd_ev;
  // four-bit mode pairs high then low nibble
  always_comb
  begin
    wr_ev = 1'b0;
    wr_rs = register_select;
    wr_d  = par_din;
    rd_ev = 1'b0;
    if (!par_mode && fifo_v)
    begin
      wr_ev = 1'b1;
      wr_rs = fifo_w.register_select;
      wr_d  = fifo_w.data;
    end
    else if (par_ev && !par_read)
    begin
      wr_ev = bus_width_select || nib_hi_r;
      wr_d  = bus_width_select ? par_din : {nib_r, par_din[7:4]};
    end
    else if (par_ev && par_read && register_select)
      rd_ev = 1'b1;
  end
  // serial host cannot see busy; stall is a guard
  assign fifo_take = !par_mode && fifo_v && !(busy_flag && !fifo_w.register_select);


  // Nibble phase only moves in 4-bit mode
  always_ff @(posedge mclk)
  begin
    if (rst_core_r)
      nib_hi_r <= 1'b0;
    else if (par_ev && !bus_width_select)
      nib_hi_r <= ~nib_hi_r;
    if (par_ev)
      nib_r <= par_din[7:4];
  end


  // Busy counter reloads on each accepted instruction; data words
  // pass even while busy, since RAM writes never stall
  // separate instruction and data holders
  // instruction holder has no read path
  always_ff @(posedge mclk)
  begin
    instr_valid <= 1'b0;
    ram_we      <= 1'b0;
    if (rst_core_r)
    begin
      instruction_holding_reg <= `LHWP_RST_BYTE;
      data_holding_reg        <= `LHWP_RST_BYTE;
      address_counter         <= `LHWP_RST_AC;
      bus_width_select        <= 1'b1;
      busy_cnt_r              <= 8'h00;
      busy_flag               <= 1'b0;
      ram_addr                <= `LHWP_RST_AC;
      ram_wdata               <= `LHWP_RST_BYTE;
    end
    else
    begin
      if (busy_cnt_r != 8'h00)
        busy_cnt_r <= busy_cnt_r - 8'h01;
      busy_flag <= (busy_cnt_r > 8'h01) || (wr_ev && !wr_rs && !busy_flag);
      if (wr_ev && !wr_rs && !busy_flag)
      begin
        instruction_holding_reg <= wr_d;
        instr_valid             <= 1'b1;
        busy_cnt_r              <= 8'(`LHWP_BUSY_CYC);
        // Only address set and width select are decoded here
        if (wr_d[`LHWP_ADDR_BIT] || wr_d[7:6] == 2'b01)
          address_counter <= wr_d[6:0];
        if (wr_d[7:5] == 3'b001)
          bus_width_select <= wr_d[`LHWP_DL_BIT];
      end
      else if (wr_ev && wr_rs)
      begin
        // holder moves to RAM at counter
        data_holding_reg <= wr_d;
        ram_we           <= 1'b1;
        ram_addr         <= address_counter;
        ram_wdata        <= wr_d;
        address_counter  <= address_counter + 7'h01;
      end
      else if (rd_ev)
      begin
        data_holding_reg <= ram_rdata;
        address_counter  <= address_counter + 7'h01;
        ram_addr         <= address_counter + 7'h01;
      end
    end
  end


  // read decode, busy on bit 7, counter below
  // Output follows select every cycle; no strobe needed to read
  always_ff @(posedge mclk)
  begin
    if (rst_core_r)
      par_dout <= `LHWP_RST_BYTE;
    else if (!register_select)
      par_dout <= {busy_flag, address_counter};
    else
      par_dout <= data_holding_reg;
  end
endmodule

// [dv/lhwp_props.sv]
// Checker on the pins of the display host write port.
// Assumes it is bound into lhwp_top; everything is sampled on mclk.
`timescale 1ns/1ps
module lhwp_props (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       rst_pin_n,
  input wire logic       scl,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       register_select,
  input wire logic [7:0] par_dout,
  input wire logic       busy_flag,
  input wire logic       bus_width_select,
  input wire logic [7:0] instruction_holding_reg,
  input wire logic [7:0] data_holding_reg,
  input wire logic [6:0] address_counter,
  input wire logic       ram_we,
  input wire logic [6:0] ram_addr,
  input wire logic       instr_valid
);
  default clocking cb @(posedge mclk); endclocking
  // Pin reset clears the outputs and would upset the $past relations
  default disable iff (rst || !rst_pin_n);
  ack_only_low_a: assert property (sda_out == 1'b0)
    else $error("data line driven high");
  ack_edge_a: assert property ($changed(sda_oe) |-> !scl)
    else $error("ack moved while clock high");
  stat_read_a: assert property ($past(!register_select) |-> par_dout == {$past(busy_flag), $past(address_counter)})
    else $error("status read wrong");
  data_read_a: assert property ($past(register_select) |-> par_dout == $past(data_holding_reg))
    else $error("data read wrong");
  busy_block_a: assert property (busy_flag |=> !instr_valid)
    else $error("instruction taken while busy");
  busy_len_a: assert property ($rose(busy_flag) |-> busy_flag[*7])
    else $error("busy too short");
  width_set_a: assert property (instr_valid && instruction_holding_reg[7:5] == 3'b001
    |-> ##[0:2] (bus_width_select == instruction_holding_reg[4]))
    else $error("width not taken");
  ram_step_a: assert property (ram_we |-> ##[0:1] (address_counter == ram_addr + 7'h01))
    else $error("counter not advanced");
  pin_reset_a: assert property (disable iff (rst) !rst_pin_n [*6] |-> !busy_flag && bus_width_select
    && address_counter == 7'h00 && !ram_we)
    else $error("pin reset ignored");
endmodule

bind lhwp_top lhwp_props i_props (.mclk, .rst, .rst_pin_n, .scl, .sda_out, .sda_oe, .register_select,
  .par_dout, .busy_flag, .bus_width_select, .instruction_holding_reg, .data_holding_reg,
  .address_counter, .ram_we, .ram_addr, .instr_valid);

// [dv/lhwp_i2c_host.sv]
// Two-wire bus master model for the display write port.
// Assumes a pull-up on the data line; clock stands high between frames.
`timescale 1ns/1ps
module lhwp_i2c_host (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  // Quarter of the 48 ns bit period
  localparam time Q = 12;
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic clocks(input int n);
    repeat (n)
    begin
      #(2*Q) scl = 1'b0;
      #(2*Q) scl = 1'b1;
    end
  endtask
  task automatic start();
    #(2*Q) sda_low = 1'b1;
    #(2*Q) scl = 1'b0;
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= -1; i--)
    begin
      #Q sda_low = (i >= 0) ? ~b[i] : 1'b0;
      #Q scl = 1'b1;
      #Q ack = ~sda;
      #Q scl = 1'b0;
    end
  endtask
  task automatic stop();
    #Q sda_low = 1'b1;
    #Q scl = 1'b1;
    #Q sda_low = 1'b0;
    #Q;
  endtask
endmodule

// [dv/lhwp_top_tb_top.sv]
// Self-checking bench for the display host write port.
// Assumes the host model and the bound checker beside it.
`timescale 1ns/1ps
module lhwp_top_tb_top;
  logic        mclk, rst, rst_pin_n, scl, sda_low, sda_oe, sda_out, busy_flag, bus_width_select;
  logic        par_mode, par_strobe, register_select, par_read, ram_we, instr_valid;
  logic [7:0]  par_din, par_dout, ihr, dhr, ram_wdata, ram_rdata;
  logic [6:0]  address_counter, ram_addr;
  logic [14:0] wq[$];
  int          n_errors, samples_checked;
  wire         sda = ~(sda_low | sda_oe);

  lhwp_top i_lhwp_top (.mclk, .rst, .rst_pin_n, .scl, .sda_in(sda), .sda_out, .sda_oe, .par_mode,
    .par_strobe, .register_select, .par_read, .par_din, .par_dout, .busy_flag, .bus_width_select,
    .instruction_holding_reg(ihr), .data_holding_reg(dhr), .address_counter, .ram_we, .ram_addr,
    .ram_wdata, .ram_rdata, .instr_valid);
  lhwp_i2c_host i_lhwp_i2c_host (.scl, .sda_low, .sda);

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk)
    if (ram_we === 1'b1)
      wq.push_back({ram_addr, ram_wdata});

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic ramchk(input logic [6:0] a, input logic [7:0] d);
    chk("ram write", wq.size() ? {1'b0, wq.pop_front()} : 16'hFFFF, {1'b0, a, d});
  endtask
  task automatic frame(input logic [7:0] b[$], input int n_ack);
    logic ack;
    i_lhwp_i2c_host.start();
    foreach (b[i])
    begin
      i_lhwp_i2c_host.wbyte(b[i], ack);
      chk("ack", 16'(ack), 16'(i < n_ack));
    end
    i_lhwp_i2c_host.stop();
  endtask
  task automatic par(input logic rs, input logic rd, input logic [7:0] d);
    @(posedge mclk);
    register_select <= rs;
    par_read <= rd;
    par_din <= d;
    par_strobe <= 1'b1;
    repeat (6) @(posedge mclk);
    par_strobe <= 1'b0;
    repeat (14) @(posedge mclk);
  endtask
  task automatic conclude();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    #100us;
    n_errors++;
    conclude();
  end

  initial
  begin
    logic [7:0] q[$];
    logic [6:0] a;
    logic [7:0] d;
    void'($urandom(74));
    {rst, rst_pin_n, par_mode, par_strobe, register_select, par_read} = 6'h28;
    par_din = 8'h00;
    ram_rdata = 8'($urandom);
    // Link reset needs scl edges while reset is high
    fork
      repeat (8) @(posedge mclk);
      i_lhwp_i2c_host.clocks(3);
    join
    @(posedge mclk);
    rst <= 1'b0;
    rst_pin_n <= 1'b1;
    i_lhwp_i2c_host.clocks(3);
    // write only, stalled core fills buffer
    a = 7'($urandom_range(63));
    q = '{8'h7C, 8'h80, {1'b1, a}, 8'h40};
    repeat (17) q.push_back(8'($urandom));
    frame(q, 19);
    @(posedge mclk);
    par_mode <= 1'b0;
    repeat (200) @(posedge mclk);
    chk("instr reg", 16'(ihr), {9'h001, a});
    chk("data reg", 16'(dhr), 16'(q[18]));
    for (int i = 4; i < 19; i++)
      ramchk(a + 7'(i - 4), q[i]);
    chk("extra writes", 16'(wq.size()), 16'h0000);
    repeat (4)
    begin
      q = '{{7'($urandom_range(61)), 1'b0}, 8'h80};
      frame(q, 0);
    end
    q = '{8'h7D, 8'h80};
    frame(q, 0);
    @(posedge mclk);
    par_mode <= 1'b1;
    a = 7'($urandom_range(63));
    d = 8'($urandom);
    par(1'b0, 1'b0, {1'b1, a});
    par(1'b0, 1'b1, 8'h00);
    chk("status", 16'(par_dout), {9'h000, a});
    par(1'b1, 1'b0, d);
    ramchk(a, d);
    par(1'b1, 1'b1, 8'h00);
    chk("data read", {dhr, 1'b0, address_counter}, {ram_rdata, 1'b0, a + 7'h02});
    par(1'b0, 1'b0, 8'h20);
    chk("width", 16'(bus_width_select), 16'h0000);
    par(1'b1, 1'b0, {d[7:4], 4'h0});
    par(1'b1, 1'b0, {d[3:0], 4'h0});
    ramchk(a + 7'h02, d);
    @(posedge mclk);
    rst_pin_n <= 1'b0;
    repeat (8) @(posedge mclk);
    chk("pin reset", {8'h00, bus_width_select, address_counter}, 16'h0080);
    rst_pin_n <= 1'b1;
    conclude();
  end
endmodule
